// ### shared/blas_defines.vh
// Constants for the byte lane access sequencer
`ifndef BLAS_DEFINES_VH
`define BLAS_DEFINES_VH

// ----------------------------------------------------------------
// Address and data widths
// ----------------------------------------------------------------
`define BLAS_ADDR_W 24
`define BLAS_BUS_W 16
`define BLAS_OPND_W 64
`define BLAS_BYTE_W 8

// ----------------------------------------------------------------
// Operand size codes
// ----------------------------------------------------------------
`define BLAS_SIZE_BYTE 2'h0
`define BLAS_SIZE_WORD 2'h1
`define BLAS_SIZE_DWORD 2'h2
`define BLAS_SIZE_QUAD 2'h3

// ----------------------------------------------------------------
// Byte counts and offsets
// ----------------------------------------------------------------
`define BLAS_OFF_ZERO 4'h0
`define BLAS_STEP_ONE 4'h1
`define BLAS_STEP_TWO 4'h2
`define BLAS_HALF_BYTES 4'h4
`define BLAS_QUAD_BYTES 4'h8

// ----------------------------------------------------------------
// Cycle kinds as {high_lane_enable_n, byte_select_lsb}
// ----------------------------------------------------------------
`define BLAS_KIND_EVEN_BYTE 2'h2
`define BLAS_KIND_ODD_BYTE 2'h1
`define BLAS_KIND_EVEN_WORD 2'h0

// ----------------------------------------------------------------
// Sequencer states, one-hot
// ----------------------------------------------------------------
`define BLAS_ST_IDLE 3'h1
`define BLAS_ST_RUN 3'h2
`define BLAS_ST_PAUSE 3'h4

`endif

// ### design/blas_cycle_plan.v
// Picks the kind and width of the next bus cycle of an operand
`timescale 1ns/1ns
`include "blas_defines.vh"

module blas_cycle_plan (
    // Position within the operand
    input wire addr_lsb_i,
    input wire [3:0] off_i,
    input wire [1:0] size_i,
    // Planned cycle
    output reg [1:0] kind_o,
    output reg [3:0] step_o,
    output reg last_o,
    output reg half_end_o
);

    reg [3:0] total;
    reg [3:0] limit;
    reg [3:0] rem;
    reg [3:0] next_off;

    always @* begin
        total = `BLAS_STEP_ONE << size_i;
        // Quad operands run as two independent halves
        if (size_i == `BLAS_SIZE_QUAD && off_i < `BLAS_HALF_BYTES) begin
            limit = `BLAS_HALF_BYTES;
        end else begin
            limit = total;
        end
        rem = limit - off_i;
        if (addr_lsb_i) begin
            kind_o = `BLAS_KIND_ODD_BYTE;
            step_o = `BLAS_STEP_ONE;
        end else if (rem >= `BLAS_STEP_TWO) begin
            kind_o = `BLAS_KIND_EVEN_WORD;
            step_o = `BLAS_STEP_TWO;
        end else begin
            kind_o = `BLAS_KIND_EVEN_BYTE;
            step_o = `BLAS_STEP_ONE;
        end
        next_off = off_i + step_o;
        last_o = (next_off == total);
        half_end_o = (size_i == `BLAS_SIZE_QUAD) && (next_off == `BLAS_HALF_BYTES);
    end

endmodule

// ### design/blas_sequencer.v
// Byte lane access sequencer: splits operands into bus cycles
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "blas_defines.vh"

module blas_sequencer #(
    parameter ADDR_W = `BLAS_ADDR_W,
    parameter BUS_W = `BLAS_BUS_W,
    parameter OPND_W = `BLAS_OPND_W
) (
    // Clock and reset
    input wire CLK_SYS_I,
    input wire RST_N_I,
    // Operand request from execution logic
    input wire REQ_VALID_I,
    input wire [ADDR_W-1:0] REQ_ADDR_I,
    input wire [1:0] REQ_SIZE_I,
    input wire REQ_WRITE_I,
    input wire [OPND_W-1:0] REQ_WDATA_I,
    output wire REQ_READY_O,
    // Operand completion
    output wire RSP_VALID_O,
    output wire [OPND_W-1:0] RSP_RDATA_O,
    // Hold between quad halves for unrelated cycles
    input wire HALF_PAUSE_I,
    // Bus cycle side
    output wire BUS_CYC_O,
    output wire BUS_WRITE_O,
    output wire [ADDR_W-1:0] BUS_ADDR_O,
    output wire HIGH_LANE_ENABLE_N_O,
    output wire BYTE_SELECT_LSB_O,
    output wire [BUS_W-1:0] MUXED_ADDR_DATA_BUS_O,
    input wire [BUS_W-1:0] MUXED_ADDR_DATA_BUS_I,
    input wire BUS_DONE_I
);

    localparam [2:0] ST_IDLE = `BLAS_ST_IDLE;
    localparam [2:0] ST_RUN = `BLAS_ST_RUN;
    localparam [2:0] ST_PAUSE = `BLAS_ST_PAUSE;
    localparam BW = `BLAS_BYTE_W;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [2:0] state_q, state_d;
    reg [ADDR_W-1:0] base_q, base_d;
    reg [3:0] off_q, off_d;
    reg [3:0] step_q, step_d;
    reg last_q, last_d;
    reg half_q, half_d;
    reg [1:0] size_q, size_d;
    reg write_q, write_d;
    reg [OPND_W-1:0] wdata_q, wdata_d;
    reg [OPND_W-1:0] rdata_q, rdata_d;
    reg ready_q, ready_d;
    reg rsp_valid_q, rsp_valid_d;
    reg [OPND_W-1:0] rsp_rdata_q, rsp_rdata_d;
    reg cyc_q, cyc_d;
    reg bwrite_q, bwrite_d;
    reg [ADDR_W-1:0] baddr_q, baddr_d;
    reg hle_n_q, hle_n_d;
    reg lsb_q, lsb_d;
    reg [BUS_W-1:0] bdata_q, bdata_d;

    // ----------------------------------------------------------------
    // Next cycle planning
    // ----------------------------------------------------------------
    reg [3:0] sel_off;
    reg [ADDR_W-1:0] sel_base;
    reg [1:0] sel_size;
    reg [OPND_W-1:0] sel_wdata;
    reg [ADDR_W-1:0] sel_addr;
    reg [OPND_W-1:0] sh_wdata;
    reg [OPND_W-1:0] merged;
    wire [1:0] plan_kind;
    wire [3:0] plan_step;
    wire plan_last;
    wire plan_half;

    always @* begin
        if (state_q == ST_IDLE) begin
            sel_off = `BLAS_OFF_ZERO;
            sel_base = REQ_ADDR_I;
            sel_size = REQ_SIZE_I;
            sel_wdata = REQ_WDATA_I;
        end else if (state_q == ST_RUN) begin
            sel_off = off_q + step_q;
            sel_base = base_q;
            sel_size = size_q;
            sel_wdata = wdata_q;
        end else begin
            sel_off = off_q;
            sel_base = base_q;
            sel_size = size_q;
            sel_wdata = wdata_q;
        end
        // Byte address wraps at the top of the 24-bit space
        sel_addr = sel_base + {{(ADDR_W-4){1'b0}}, sel_off};
        sh_wdata = sel_wdata >> {sel_off[2:0], 3'h0};
    end

    blas_cycle_plan u_plan (
        .addr_lsb_i(sel_addr[0]),
        .off_i(sel_off),
        .size_i(sel_size),
        .kind_o(plan_kind),
        .step_o(plan_step),
        .last_o(plan_last),
        .half_end_o(plan_half)
    );

    // ----------------------------------------------------------------
    // Read lane gathering
    // ----------------------------------------------------------------
    integer i;
    always @* begin
        merged = rdata_q;
        for (i = 0; i < OPND_W / BW; i = i + 1) begin
            if (i == off_q) begin
                if (lsb_q) begin
                    merged[i*BW +: BW] = MUXED_ADDR_DATA_BUS_I[BW +: BW];
                end else begin
                    merged[i*BW +: BW] = MUXED_ADDR_DATA_BUS_I[0 +: BW];
                end
            end else if (i == off_q + 1 && step_q == `BLAS_STEP_TWO) begin
                merged[i*BW +: BW] = MUXED_ADDR_DATA_BUS_I[BW +: BW];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    task launch;
        begin
            state_d = ST_RUN;
            off_d = sel_off;
            step_d = plan_step;
            last_d = plan_last;
            half_d = plan_half;
            cyc_d = 1'b1;
            baddr_d = sel_addr;
            {hle_n_d, lsb_d} = plan_kind;
            if (plan_kind == `BLAS_KIND_ODD_BYTE) begin
                bdata_d = {sh_wdata[0 +: BW], {BW{1'b0}}};
            end else if (plan_kind == `BLAS_KIND_EVEN_BYTE) begin
                bdata_d = {{BW{1'b0}}, sh_wdata[0 +: BW]};
            end else begin
                bdata_d = sh_wdata[0 +: BUS_W];
            end
        end
    endtask

    always @* begin
        state_d = state_q;
        base_d = base_q;
        off_d = off_q;
        step_d = step_q;
        last_d = last_q;
        half_d = half_q;
        size_d = size_q;
        write_d = write_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        ready_d = ready_q;
        rsp_valid_d = 1'b0;
        rsp_rdata_d = rsp_rdata_q;
        cyc_d = cyc_q;
        bwrite_d = bwrite_q;
        baddr_d = baddr_q;
        hle_n_d = hle_n_q;
        lsb_d = lsb_q;
        bdata_d = bdata_q;
        case (state_q)
            ST_IDLE: begin
                if (REQ_VALID_I && ready_q) begin
                    base_d = REQ_ADDR_I;
                    size_d = REQ_SIZE_I;
                    write_d = REQ_WRITE_I;
                    bwrite_d = REQ_WRITE_I;
                    wdata_d = REQ_WDATA_I;
                    rdata_d = {OPND_W{1'b0}};
                    ready_d = 1'b0;
                    launch;
                end
            end
            ST_RUN: begin
                if (BUS_DONE_I) begin
                    rdata_d = merged;
                    if (last_q) begin
                        state_d = ST_IDLE;
                        cyc_d = 1'b0;
                        ready_d = 1'b1;
                        rsp_valid_d = 1'b1;
                        rsp_rdata_d = write_q ? {OPND_W{1'b0}} : merged;
                    end else if (half_q && HALF_PAUSE_I) begin
                        // Bus is released so other masters' cycles fit here
                        state_d = ST_PAUSE;
                        cyc_d = 1'b0;
                        off_d = sel_off;
                    end else begin
                        launch;
                    end
                end
            end
            ST_PAUSE: begin
                if (!HALF_PAUSE_I) begin
                    launch;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cyc_d = 1'b0;
                ready_d = 1'b1;
            end
        endcase
    end

    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            base_q <= {ADDR_W{1'b0}};
            off_q <= `BLAS_OFF_ZERO;
            step_q <= `BLAS_STEP_ONE;
            last_q <= 1'b0;
            half_q <= 1'b0;
            size_q <= `BLAS_SIZE_BYTE;
            write_q <= 1'b0;
            wdata_q <= {OPND_W{1'b0}};
            rdata_q <= {OPND_W{1'b0}};
            ready_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= {OPND_W{1'b0}};
            cyc_q <= 1'b0;
            bwrite_q <= 1'b0;
            baddr_q <= {ADDR_W{1'b0}};
            hle_n_q <= 1'b1;
            lsb_q <= 1'b0;
            bdata_q <= {BUS_W{1'b0}};
        end else begin
            state_q <= state_d;
            base_q <= base_d;
            off_q <= off_d;
            step_q <= step_d;
            last_q <= last_d;
            half_q <= half_d;
            size_q <= size_d;
            write_q <= write_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_rdata_q <= rsp_rdata_d;
            cyc_q <= cyc_d;
            bwrite_q <= bwrite_d;
            baddr_q <= baddr_d;
            hle_n_q <= hle_n_d;
            lsb_q <= lsb_d;
            bdata_q <= bdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign REQ_READY_O = ready_q;
    assign RSP_VALID_O = rsp_valid_q;
    assign RSP_RDATA_O = rsp_rdata_q;
    assign BUS_CYC_O = cyc_q;
    assign BUS_WRITE_O = bwrite_q;
    assign BUS_ADDR_O = baddr_q;
    assign HIGH_LANE_ENABLE_N_O = hle_n_q;
    assign BYTE_SELECT_LSB_O = lsb_q;
    assign MUXED_ADDR_DATA_BUS_O = bdata_q;

endmodule

// ### tb/blas_sequencer_properties.sv
// Port-level checker for the byte lane access sequencer
`timescale 1ns/1ns
module blas_seq_chk #(
    parameter ADDR_W = 24,
    parameter BUS_W = 16
) (
    // Clock and reset
    input wire CLK_SYS_I,
    input wire RST_N_I,
    // Request side
    input wire REQ_VALID_I,
    input wire [ADDR_W-1:0] REQ_ADDR_I,
    input wire REQ_READY_O,
    input wire RSP_VALID_O,
    input wire HALF_PAUSE_I,
    // Bus side
    input wire BUS_CYC_O,
    input wire BUS_WRITE_O,
    input wire [ADDR_W-1:0] BUS_ADDR_O,
    input wire HIGH_LANE_ENABLE_N_O,
    input wire BYTE_SELECT_LSB_O,
    input wire [BUS_W-1:0] MUXED_ADDR_DATA_BUS_O,
    input wire BUS_DONE_I
);
    wire hle_n = HIGH_LANE_ENABLE_N_O;
    wire lsb = BYTE_SELECT_LSB_O;
    default clocking dcb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);
    // ------------------------------------------------------------
    // Cycle shape and sequencing
    // ------------------------------------------------------------
    kind_legal_a: assert property (
        BUS_CYC_O |-> !(hle_n && lsb)) else $error("illegal cycle kind");
    lsb_addr_a: assert property (
        BUS_CYC_O |-> lsb == BUS_ADDR_O[0]) else $error("lsb differs from address");
    start_seq_a: assert property (
        REQ_VALID_I && REQ_READY_O |=> BUS_CYC_O && BUS_ADDR_O == $past(REQ_ADDR_I))
        else $error("operand start wrong");
    hold_cyc_a: assert property (
        BUS_CYC_O && !BUS_DONE_I |=> BUS_CYC_O && $stable(BUS_ADDR_O) && $stable(hle_n))
        else $error("cycle changed before done");
    no_gap_a: assert property (
        BUS_CYC_O && BUS_DONE_I && !HALF_PAUSE_I |=> BUS_CYC_O != RSP_VALID_O)
        else $error("idle gap inside operand");
    addr_step_a: assert property (
        BUS_CYC_O && BUS_DONE_I ##1 BUS_CYC_O |-> BUS_ADDR_O ==
        $past(BUS_ADDR_O) + (($past(hle_n) || $past(lsb)) ? 24'h1 : 24'h2))
        else $error("address step wrong");
    low_dc_a: assert property (
        BUS_CYC_O && BUS_WRITE_O && lsb |-> MUXED_ADDR_DATA_BUS_O[7:0] == 8'h00)
        else $error("low lane not idle");
    high_dc_a: assert property (
        BUS_CYC_O && BUS_WRITE_O && hle_n |-> MUXED_ADDR_DATA_BUS_O[15:8] == 8'h00)
        else $error("high lane not idle");
    rsp_end_a: assert property (
        RSP_VALID_O |-> REQ_READY_O && !BUS_CYC_O ##1 !RSP_VALID_O)
        else $error("response not a clean pulse");
    cover property (BUS_CYC_O && lsb && BUS_DONE_I ##1 BUS_CYC_O && !lsb);
    cover property (HALF_PAUSE_I && !BUS_CYC_O && !REQ_READY_O);
    cover property (RSP_VALID_O && REQ_VALID_I);
endmodule

bind blas_sequencer blas_seq_chk #(.ADDR_W(ADDR_W), .BUS_W(BUS_W)) blas_seq_chk_inst (
    .CLK_SYS_I, .RST_N_I, .REQ_VALID_I, .REQ_ADDR_I, .REQ_READY_O, .RSP_VALID_O,
    .HALF_PAUSE_I, .BUS_CYC_O, .BUS_WRITE_O, .BUS_ADDR_O, .HIGH_LANE_ENABLE_N_O,
    .BYTE_SELECT_LSB_O, .MUXED_ADDR_DATA_BUS_O, .BUS_DONE_I);

// ### tb/blas_bank_model.sv
// Two eight-bit memory banks sharing one word address
`timescale 1ns/1ns
module blas_bank_model (
    // Clock and wait control
    input wire clk_i,
    input wire [3:0] wait_i,
    // Bus from the sequencer
    input wire cyc_i,
    input wire write_i,
    input wire [23:0] addr_i,
    input wire hle_n_i,
    input wire lsb_i,
    input wire [15:0] wdata_i,
    output reg [15:0] rdata_o,
    output reg done_o
);
    reg [7:0] bank_lo [0:127];
    reg [7:0] bank_hi [0:127];
    reg [3:0] cnt_q = 4'h0;
    wire [6:0] wa = addr_i[7:1];
    initial done_o = 1'b0;
    initial rdata_o = 16'hA55A;
    // Unselected lanes toggle so stale data never looks valid
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (cyc_i && !done_o) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= wait_i) begin
                cnt_q <= 4'h0;
                done_o <= 1'b1;
                rdata_o <= {hle_n_i ? ~rdata_o[15:8] : bank_hi[wa],
                            lsb_i ? ~rdata_o[7:0] : bank_lo[wa]};
                if (write_i && !lsb_i) bank_lo[wa] <= wdata_i[7:0];
                if (write_i && !hle_n_i) bank_hi[wa] <= wdata_i[15:8];
            end
        end
    end
endmodule

// ### tb/tb_byte_lane_access_sequencer.sv
// Self-checking bench for the byte lane access sequencer
`timescale 1ns/1ns
module tb_byte_lane_access_sequencer;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg vld = 1'b0;
    reg [23:0] adr = 24'h0;
    reg [1:0] sz = 2'h0;
    reg wr = 1'b0;
    reg [63:0] wd = 64'h0;
    reg pause = 1'b0;
    reg [3:0] wt = 4'h0;
    wire rdy, rsp, cyc, bwr, hle_n, lsb, done;
    wire [63:0] rd;
    wire [23:0] badr;
    wire [15:0] bo, bi;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer ticks = 0;
    reg [25:0] seen [$];
    reg [63:0] got;
    always #4 clk = ~clk;
    blas_sequencer blas_sequencer_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .REQ_VALID_I(vld), .REQ_ADDR_I(adr), .REQ_SIZE_I(sz), .REQ_WRITE_I(wr),
        .REQ_WDATA_I(wd), .REQ_READY_O(rdy), .RSP_VALID_O(rsp), .RSP_RDATA_O(rd),
        .HALF_PAUSE_I(pause), .BUS_CYC_O(cyc), .BUS_WRITE_O(bwr), .BUS_ADDR_O(badr),
        .HIGH_LANE_ENABLE_N_O(hle_n), .BYTE_SELECT_LSB_O(lsb),
        .MUXED_ADDR_DATA_BUS_O(bo), .MUXED_ADDR_DATA_BUS_I(bi), .BUS_DONE_I(done));
    blas_bank_model blas_bank_model_inst (.clk_i(clk), .wait_i(wt), .cyc_i(cyc),
        .write_i(bwr), .addr_i(badr), .hle_n_i(hle_n), .lsb_i(lsb), .wdata_i(bo),
        .rdata_o(bi), .done_o(done));
    // Completed bus cycles, plus a guard against hangs
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (cyc === 1'b1 && done === 1'b1)
            seen.push_back({badr, hle_n, lsb});
        if (ticks == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task cmp_val(input string what, input [63:0] e, input [63:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH %s expected %h seen %h", what, e, g);
            end
        end
    endtask
    // Expected cycles: odd start takes a byte, halves of a quad never merge
    task cmp_seq(input [23:0] a, input [1:0] s);
        integer off, n, lim, st;
        reg [23:0] ca;
        begin
            n = 1 << s;
            off = 0;
            while (off < n) begin
                ca = a + off;
                lim = (n == 8 && off < 4) ? 4 : n;
                st = (ca[0] || lim - off < 2) ? 1 : 2;
                cmp_val("cycle", {ca, ca[0] ? 2'b01 : {st == 1, 1'b0}},
                    seen.size() > 0 ? seen.pop_front() : 26'bx);
                off = off + st;
            end
            cmp_val("extra cycles", 64'h0, seen.size());
        end
    endtask
    task op(input [23:0] a, input [1:0] s, input w, input [63:0] d);
        integer k;
        begin
            seen.delete();
            @(posedge clk);
            vld <= 1'b1;
            adr <= a;
            sz <= s;
            wr <= w;
            wd <= d;
            @(posedge clk);
            vld <= 1'b0;
            for (k = 0; k < 300 && rsp !== 1'b1; k = k + 1)
                @(negedge clk);
            got = rd;
            cmp_val("response seen", 64'h1, rsp);
        end
    endtask
    task rt(input [23:0] a, input [1:0] s, input [63:0] d);
        begin
            op(a, s, 1'b1, d);
            cmp_seq(a, s);
            cmp_val("write rdata", 64'h0, got);
            op(a, s, 1'b0, 64'h0);
            cmp_seq(a, s);
            cmp_val("read rdata", d & ~({64{1'b1}} << (8 << s)), got);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_sweep;
        integer s;
        begin
            for (s = 0; s < 4; s = s + 1) begin
                rt(24'h000040, s[1:0], 64'h8877665544332211);
                rt(24'h000051, s[1:0], 64'h1122334455667788);
            end
            $display("test sweep done");
        end
    endtask
    task t_slow;
        begin
            wt <= 4'h3;
            rt(24'hFFFFFD, 2'h2, 64'h00000000CAFEF00D);
            wt <= 4'h0;
            $display("test slow wrap done");
        end
    endtask
    task t_pause;
        integer k;
        begin
            @(posedge clk);
            pause <= 1'b1;
            fork
                op(24'h000061, 2'h3, 1'b1, 64'hF0E1D2C3B4A59687);
                begin
                    for (k = 0; k < 50 && seen.size() < 3; k = k + 1)
                        @(negedge clk);
                    repeat (4) @(negedge clk);
                    cmp_val("paused bus", 64'h3, {cyc, seen.size()});
                    @(posedge clk);
                    pause <= 1'b0;
                end
            join
            cmp_seq(24'h000061, 2'h3);
            $display("test pause done");
        end
    endtask
    // Reset cut into a quad read; outputs must fall back to idle at once
    task t_reset;
        begin
            @(posedge clk);
            vld <= 1'b1;
            adr <= 24'h000040;
            sz <= 2'h3;
            wr <= 1'b0;
            @(posedge clk);
            vld <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b0;
            @(negedge clk);
            cmp_val("reset state", {5'h12, 40'h0}, {rdy, rsp, cyc, hle_n, lsb, badr, bo});
            cmp_val("reset rdata", 64'h0, rd);
            @(posedge clk);
            rst_n <= 1'b1;
            repeat (2) @(negedge clk);
            cmp_val("after release", {5'h12, 40'h0}, {rdy, rsp, cyc, hle_n, lsb, badr, bo});
            seen.delete();
            $display("test reset done");
        end
    endtask
    task close_out;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_sweep;
        t_slow;
        t_reset;
        t_pause;
        close_out;
    end
endmodule
